// File: tig_pkg.sv
package tig_pkg;
  // Bus geometry
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_MODE = 16'hFFBC;
  localparam logic [15:0] IDX_FALL = 16'hFFBD;
  localparam logic [15:0] IDX_RISE = 16'hFFBE;
  localparam logic [15:0] IDX_IRR  = 16'hFFC0;
  localparam logic [15:0] IDX_IEN  = 16'hFFC1;
  localparam logic [15:0] IDX_PMR  = 16'hFFC2;

  // Mode register fields
  localparam int MODE_OVF_HI = 7;
  localparam int MODE_OVF_LO = 6;
  localparam int MODE_OVF_IE = 5;
  localparam int MODE_IEGS = 4;
  localparam int MODE_CCLR = 2;
  localparam int MODE_CKS  = 0;
  localparam logic [7:0] MODE_CFG_MASK = 8'h3F;

  // Single-bit fields of the system registers
  localparam int IRR_TG_BIT  = 0;
  localparam int IEN_TG_BIT  = 0;
  localparam int PMR_CAP_BIT = 0;

  // Reset values and the counter's top value
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CAP_RST  = 8'h00;
  localparam logic [7:0] CNT_RST  = 8'h00;
  localparam logic [7:0] CNT_MAX  = 8'hFF;

  // Clear-select and clock-select encodings
  localparam logic [1:0] CLR_NONE  = 2'h0;
  localparam logic [1:0] CLR_FALL  = 2'h1;
  localparam logic [1:0] CLR_RISE  = 2'h2;
  localparam logic [1:0] CLR_BOTH  = 2'h3;
  localparam logic [1:0] CKS_DIV64 = 2'h0;
  localparam logic [1:0] CKS_DIV32 = 2'h1;
  localparam logic [1:0] CKS_DIV2  = 2'h2;
  localparam logic [1:0] CKS_SUB2  = 2'h3;

  // Prescaler
  localparam int         PRE_W      = 6;
  localparam logic [5:0] DIV64_LAST = 6'h3F;
  localparam logic [4:0] DIV32_LAST = 5'h1F;

  // Least capture pulse width, in clock periods
  localparam int CAP_MIN_PULSE = 2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {
    TIG_SEL_MODE,
    TIG_SEL_FALL,
    TIG_SEL_RISE,
    TIG_SEL_IRR,
    TIG_SEL_IEN,
    TIG_SEL_PMR,
    TIG_SEL_NONE
  } tig_sel_t;
endpackage

// File: tig_timer.sv
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
// Contract
// R1 - 8-bit counter steps once per selected tick
// R2 - Four ticks: sys/64, sys/32, sys/2, sub/2
// R3 - Pin select 1 captures, 0 interval only
// R4 - Changing pin select may cause spurious capture
// R5 - Falling edge copies counter to falling register
// R6 - Rising edge copies counter to rising register
// R7 - Edge select 1: falling capture sets request
// R8 - Edge select 0: rising capture sets request
// R9 - Interrupt needs request flag and enable
// R10 - Wrap with overflow enable sets request
// R11 - Counter hidden from the bus
// R12 - Reset zeroes counter, captures, mode register
// R13 - Capture registers read-only, writes ignored
// R14 - Overflow flags: hardware sets, write 0 clears
// R15 - Overflow while input high with pin select 1 sets bit 7
// R16 - Mode register holds flags, enables, selects
// R17 - Clear counter on chosen capture edges
// R18 - Source holds pulses two clock periods
// R19 - Low-speed states count only on sub/2
// R20 - Clear select: none, fall, rise, both
// R21 - Clock select: /64, /32, /2, sub/2
// R22 - Overflow while low or interval sets low flag
// R23 - Synchronise pin, detect edges from samples
module tig_timer
  import tig_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  // Capture pin, sub-clock tick and chip state
  input  wire logic              i_cap_pin,
  input  wire logic              i_sub_tick,
  input  wire logic              i_low_speed,
  // AXI4-Lite write address
  input  wire logic              i_awvalid,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  output var  logic              o_awready,
  // AXI4-Lite write data
  input  wire logic              i_wvalid,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic [3:0]        i_wstrb,
  output var  logic              o_wready,
  // AXI4-Lite write response
  output var  logic              o_bvalid,
  output var  logic [1:0]        o_bresp,
  input  wire logic              i_bready,
  // AXI4-Lite read
  input  wire logic              i_arvalid,
  input  wire logic [ADDR_W-1:0] i_araddr,
  output var  logic              o_arready,
  output var  logic              o_rvalid,
  output var  logic [DATA_W-1:0] o_rdata,
  output var  logic [1:0]        o_rresp,
  input  wire logic              i_rready,
  // Interrupt
  output var  logic              o_irq
);

  function automatic tig_sel_t decode(input logic [ADDR_W-1:0] a);
    tig_sel_t s;
    s = TIG_SEL_NONE;
    if (a[1:0] == 2'h0) begin
      case (a[ADDR_W-1:2])
        IDX_MODE: s = TIG_SEL_MODE;
        IDX_FALL: s = TIG_SEL_FALL;
        IDX_RISE: s = TIG_SEL_RISE;
        IDX_IRR:  s = TIG_SEL_IRR;
        IDX_IEN:  s = TIG_SEL_IEN;
        IDX_PMR:  s = TIG_SEL_PMR;
        default:  s = TIG_SEL_NONE;
      endcase
    end
    return s;
  endfunction

  logic [7:0]        mode;
  logic [7:0]        fall_cap;
  logic [7:0]        rise_cap;
  logic [7:0]        cnt;
  logic              irq_flag;
  logic              irq_en;
  logic              cap_sel;
  logic [ADDR_W-1:0] aw_addr;
  logic [7:0]        w_byte;
  logic              w_lane0;
  logic [PRE_W-1:0]  pre;
  logic              sub_half;
  logic              sync1;
  logic              sync2;
  logic              lvl_prev;
  logic              lvl;
  logic              rise;
  logic              fall;
  logic              tick;
  logic              clr_now;
  logic              ovf;
  logic              wr_go;
  tig_sel_t          wsel;
  logic [1:0]        cks;
  logic [1:0]        cclr;

  assign cks  = mode[MODE_CKS +: 2];
  assign cclr = mode[MODE_CCLR +: 2];

  // Write address and data are taken independently; each ready
  // drops while its item is held and rises with the response.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_awready <= 1'b1;
      aw_addr   <= '0;
    end else if (o_awready && i_awvalid) begin
      o_awready <= 1'b0;
      aw_addr   <= i_awaddr;
    end else if (o_bvalid && i_bready) begin
      o_awready <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_wready <= 1'b1;
      w_byte   <= 8'h00;
      w_lane0  <= 1'b0;
    end else if (o_wready && i_wvalid) begin
      o_wready <= 1'b0;
      w_byte   <= i_wdata[7:0];
      w_lane0  <= i_wstrb[0];
    end else if (o_bvalid && i_bready) begin
      o_wready <= 1'b1;
    end
  end

  assign wr_go = !o_awready && !o_wready && !o_bvalid;
  assign wsel  = decode(aw_addr);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_bvalid <= 1'b0;
      o_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      o_bvalid <= 1'b1;
      o_bresp  <= (wsel == TIG_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (o_bvalid && i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // Reads answer on the same edge that takes the address. The counter has
  // no address, so it can be neither read nor written.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= RESP_OKAY;
    end else if (o_arready && i_arvalid) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rresp   <= RESP_OKAY;
      o_rdata   <= '0;
      case (decode(i_araddr)) // see R11
        TIG_SEL_MODE: o_rdata[7:0] <= mode;
        TIG_SEL_FALL: o_rdata[7:0] <= fall_cap;
        TIG_SEL_RISE: o_rdata[7:0] <= rise_cap;
        TIG_SEL_IRR:  o_rdata[IRR_TG_BIT] <= irq_flag;
        TIG_SEL_IEN:  o_rdata[IEN_TG_BIT] <= irq_en;
        TIG_SEL_PMR:  o_rdata[PMR_CAP_BIT] <= cap_sel;
        default:      o_rresp <= RESP_SLVERR;
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // Prescaler: a free-running count gives the /64, /32 and /2 ticks
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pre <= '0;
    end else begin
      pre <= pre + 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sub_half <= 1'b0;
    end else if (i_sub_tick) begin
      sub_half <= !sub_half;
    end
  end

  always_comb begin
    case (cks) // see R2 see R21
      CKS_DIV64: tick = (pre == DIV64_LAST);
      CKS_DIV32: tick = (pre[4:0] == DIV32_LAST);
      CKS_DIV2:  tick = pre[0];
      CKS_SUB2:  tick = i_sub_tick && sub_half;
      default:   tick = 1'b0;
    endcase
    // Only the sub-clock keeps running in the low-speed states
    if (i_low_speed && cks != CKS_SUB2) begin // see R19
      tick = 1'b0;
    end
  end

  // Two-flop synchroniser, then an edge detector on the gated level.
  // Gating by the pin select means dropping it while the pin is high
  // looks like a falling edge; that spurious capture is accepted.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sync1    <= 1'b0;
      sync2    <= 1'b0;
      lvl_prev <= 1'b0;
    end else begin
      sync1    <= i_cap_pin; // see R23
      sync2    <= sync1;
      lvl_prev <= lvl;
    end
  end

  assign lvl  = cap_sel && sync2; // see R3 see R4
  assign rise = lvl && !lvl_prev; // see R23
  assign fall = !lvl && lvl_prev;

  assign clr_now = (rise && cclr[1]) || (fall && cclr[0]); // see R17 see R20
  assign ovf     = tick && !clr_now && (cnt == CNT_MAX);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt <= CNT_RST; // see R12
    end else if (clr_now) begin
      cnt <= CNT_RST;
    end else if (tick) begin
      cnt <= cnt + 1'b1; // see R1
    end
  end

  // Captures take the count as it stands before any clear
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      fall_cap <= CAP_RST;
      rise_cap <= CAP_RST;
    end else begin
      if (fall) begin
        fall_cap <= cnt; // see R5 see R13
      end
      if (rise) begin
        rise_cap <= cnt; // see R6
      end
    end
  end

  // Mode register: flags only clear on a written 0, and a set in the
  // same cycle wins over that clear.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      mode <= MODE_RST; // see R12
    end else begin
      if (wr_go && wsel == TIG_SEL_MODE && w_lane0) begin
        mode <= (w_byte & MODE_CFG_MASK) | (mode & w_byte & ~MODE_CFG_MASK); // see R16 see R14
      end
      if (ovf && lvl) begin
        mode[MODE_OVF_HI] <= 1'b1; // see R15
      end
      if (ovf && !lvl) begin
        mode[MODE_OVF_LO] <= 1'b1; // see R22
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      irq_flag <= 1'b0;
    end else if ((rise && !mode[MODE_IEGS]) || (fall && mode[MODE_IEGS]) ||
                 (ovf && mode[MODE_OVF_IE])) begin
      irq_flag <= 1'b1; // see R7 see R8 see R10
    end else if (wr_go && wsel == TIG_SEL_IRR && w_lane0 && !w_byte[IRR_TG_BIT]) begin
      irq_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      irq_en  <= 1'b0;
      cap_sel <= 1'b0;
    end else if (wr_go && w_lane0) begin
      if (wsel == TIG_SEL_IEN) begin
        irq_en <= w_byte[IEN_TG_BIT];
      end
      if (wsel == TIG_SEL_PMR) begin
        cap_sel <= w_byte[PMR_CAP_BIT];
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= irq_flag && irq_en; // see R9
    end
  end

  cnt_step_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R1
    tick && !clr_now |=> cnt == $past(cnt) + 8'h01)
    else $error("counter did not step on tick");

  low_speed_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R19
    i_low_speed && cks != CKS_SUB2 && !clr_now |=> $stable(cnt))
    else $error("counter moved in low-speed state");

  fall_capture_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R5
    i_cap_pin && cap_sel ##1 !i_cap_pin && cap_sel && $stable(cap_sel) ##2 !i_cap_pin
      |=> fall_cap == $past(cnt))
    else $error("falling capture missed");

  rise_capture_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R6
    rise |=> rise_cap == $past(cnt) && $stable(fall_cap))
    else $error("rising capture wrong");

  edge_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R17
    (rise && cclr == CLR_RISE) || (fall && cclr == CLR_FALL) || (lvl != lvl_prev && cclr == CLR_BOTH)
      |=> cnt == CNT_RST)
    else $error("counter not cleared on edge");

  ovf_high_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R15
    tick && cnt == CNT_MAX && !clr_now && lvl |=> mode[MODE_OVF_HI] && (irq_flag || !$past(mode[MODE_OVF_IE])))
    else $error("high overflow not flagged");

  ovf_low_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R22
    ovf && !cap_sel |=> mode[MODE_OVF_LO] && !$rose(mode[MODE_OVF_HI]))
    else $error("low overflow not flagged");

  flag_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R14
    mode[MODE_OVF_HI] && !(wr_go && wsel == TIG_SEL_MODE && w_lane0 && !w_byte[MODE_OVF_HI])
      |=> mode[MODE_OVF_HI])
    else $error("overflow flag lost without a zero write");

  cap_irq_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R7 see R8
    (fall && mode[MODE_IEGS]) || (rise && !mode[MODE_IEGS]) |=> irq_flag)
    else $error("capture did not raise request");

  irq_gate_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R9
    o_irq |-> $past(irq_flag) && $past(irq_en))
    else $error("interrupt without flag and enable");

  ovf_irq_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R10
    ovf && mode[MODE_OVF_IE] |=> irq_flag)
    else $error("overflow did not raise request");

  cnt_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R1
    !tick && !clr_now |=> $stable(cnt))
    else $error("counter moved without a tick");

  fall_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R13
    !fall |=> $stable(fall_cap))
    else $error("falling capture changed without an edge");

  rise_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R13
    !rise |=> $stable(rise_cap))
    else $error("rising capture changed without an edge");

  low_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see R14
    mode[MODE_OVF_LO] && !(wr_go && wsel == TIG_SEL_MODE && w_lane0 && !w_byte[MODE_OVF_LO])
      |=> mode[MODE_OVF_LO])
    else $error("low overflow flag lost without a zero write");

endmodule
`default_nettype wire

// File: tig_pulse_src.sv
`timescale 1ns/1ns
`default_nettype none
module tig_pulse_src (
  // Clock
  input  wire logic i_clk,
  // Capture pin
  output var  logic o_pin
);
  initial o_pin = 1'b0;

  // Clamped to two cycles: shorter pulses may be lost by the edge detector
  task automatic drive(input logic lvl, input int n);
    int k;
    k = (n < 2) ? 2 : n;
    o_pin <= lvl;
    repeat (k) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// File: tig_timer_test.sv
`timescale 1ns/1ns
`default_nettype none
module tig_timer_test
  import tig_pkg::*;
;
  logic              i_clk_sys;
  logic              i_rst;
  wire logic         i_cap_pin;
  logic              i_sub_tick = 1'b0;
  logic              i_low_speed;
  logic              i_awvalid;
  logic [ADDR_W-1:0] i_awaddr;
  logic              o_awready;
  logic              i_wvalid;
  logic [DATA_W-1:0] i_wdata;
  logic [3:0]        i_wstrb;
  logic              o_wready;
  logic              o_bvalid;
  logic [1:0]        o_bresp;
  logic              i_bready;
  logic              i_arvalid;
  logic [ADDR_W-1:0] i_araddr;
  logic              o_arready;
  logic              o_rvalid;
  logic [DATA_W-1:0] o_rdata;
  logic [1:0]        o_rresp;
  logic              i_rready;
  logic              o_irq;
  int                errors;
  int                compares;
  int                sub_cnt = 0;
  logic [31:0]       rd_data;
  logic [1:0]        rd_resp;

  always #25 i_clk_sys = ~i_clk_sys;

  tig_timer u_dut (.i_clk_sys, .i_rst, .i_cap_pin, .i_sub_tick, .i_low_speed, .i_awvalid, .i_awaddr,
    .o_awready, .i_wvalid, .i_wdata, .i_wstrb, .o_wready, .o_bvalid, .o_bresp, .i_bready, .i_arvalid,
    .i_araddr, .o_arready, .o_rvalid, .o_rdata, .o_rresp, .i_rready, .o_irq);
  tig_pulse_src u_src (.i_clk(i_clk_sys), .o_pin(i_cap_pin));

  // Sub-clock pulse every sixth cycle, so sub/2 steps every twelve
  always @(posedge i_clk_sys) begin
    sub_cnt <= (sub_cnt == 5) ? 0 : sub_cnt + 1;
    i_sub_tick <= (sub_cnt == 5);
  end

  task automatic chk(input logic [31:0] act, input logic [31:0] exp, input string what);
    compares++;
    if (act !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, act, exp);
    end
  endtask

  task automatic chk_rng(input logic [7:0] act, input int lo, input int hi, input string what);
    compares++;
    if ((^act === 1'bx) || act < lo || act > hi) begin
      errors++;
      $display("mismatch at %0t: %s got %0d want %0d..%0d", $time, what, act, lo, hi);
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    i_awaddr <= {idx, 2'b00};
    i_wdata <= {24'h000000, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge i_clk_sys);
      if (aw && o_awready) begin
        aw = 1'b0;
        i_awvalid <= 1'b0;
      end
      if (w && o_wready) begin
        w = 1'b0;
        i_wvalid <= 1'b0;
      end
    end
    do @(posedge i_clk_sys); while (!o_bvalid);
    chk({30'h0, o_bresp}, {30'h0, er}, "write response");
  endtask

  task automatic rd(input logic [15:0] idx);
    i_araddr <= {idx, 2'b00};
    i_arvalid <= 1'b1;
    do @(posedge i_clk_sys); while (!o_arready);
    i_arvalid <= 1'b0;
    do @(posedge i_clk_sys); while (!o_rvalid);
    rd_data = o_rdata;
    rd_resp = o_rresp;
  endtask

  task automatic rdc(input logic [15:0] idx, input logic [7:0] exp, input string what);
    rd(idx);
    chk(rd_data, {24'h000000, exp}, what);
  endtask

  task automatic t_reset();
    logic [15:0] idx [6] = '{IDX_MODE, IDX_FALL, IDX_RISE, IDX_IRR, IDX_IEN, IDX_PMR};
    foreach (idx[k]) rdc(idx[k], 8'h00, "reset value");
    chk({31'h0, o_irq}, 32'h0, "irq after reset");
  endtask

  task automatic t_regs();
    wr(IDX_MODE, 8'hFF, RESP_OKAY);
    rdc(IDX_MODE, 8'h3F, "mode readback");
    wr(IDX_MODE, 8'h00, RESP_OKAY);
    wr(IDX_FALL, 8'h5A, RESP_OKAY);
    rdc(IDX_FALL, 8'h00, "falling capture write");
    wr(IDX_RISE, 8'hA5, RESP_OKAY);
    rdc(IDX_RISE, 8'h00, "rising capture write");
    wr(16'hFFBF, 8'h11, RESP_SLVERR);
    rd(16'hFFBF);
    chk({30'h0, rd_resp}, {30'h0, RESP_SLVERR}, "unmapped read");
  endtask

  task automatic t_clk();
    int dv [4] = '{64, 32, 2, 12};
    int e;
    wr(IDX_PMR, 8'h01, RESP_OKAY);
    for (int ls = 0; ls < 2; ls++) begin
      i_low_speed <= ls[0];
      for (int k = 0; k < 4; k++) begin
        wr(IDX_MODE, {4'h0, CLR_RISE, k[1:0]}, RESP_OKAY);
        u_src.drive(1'b1, 256);
        u_src.drive(1'b0, 20);
        e = (ls == 1 && k != 3) ? 0 : 256 / dv[k];
        rd(IDX_FALL);
        chk_rng(rd_data[7:0], e - (e > 0), e + (e > 0), "pulse width count");
      end
    end
    i_low_speed <= 1'b0;
  endtask

  task automatic t_irq();
    wr(IDX_MODE, 8'h0C, RESP_OKAY);
    i_low_speed <= 1'b1;
    u_src.drive(1'b1, 10);
    u_src.drive(1'b0, 10);
    wr(IDX_MODE, 8'h00, RESP_OKAY);
    wr(IDX_IRR, 8'h00, RESP_OKAY);
    u_src.drive(1'b1, 10);
    i_low_speed <= 1'b0;
    // Both edges cleared the count and the slow state froze it, so the rise takes zero
    rdc(IDX_RISE, 8'h00, "rise capture of frozen count");
    rdc(IDX_IRR, 8'h01, "rising request");
    chk({31'h0, o_irq}, 32'h0, "irq masked");
    wr(IDX_IEN, 8'h01, RESP_OKAY);
    repeat (2) @(posedge i_clk_sys);
    chk({31'h0, o_irq}, 32'h1, "irq enabled");
    wr(IDX_IRR, 8'h00, RESP_OKAY);
    wr(IDX_MODE, 8'h10, RESP_OKAY);
    u_src.drive(1'b0, 10);
    rdc(IDX_IRR, 8'h01, "falling request");
    wr(IDX_IRR, 8'h00, RESP_OKAY);
    u_src.drive(1'b1, 10);
    rdc(IDX_IRR, 8'h00, "rising ignored");
    u_src.drive(1'b0, 10);
    wr(IDX_IEN, 8'h00, RESP_OKAY);
  endtask

  task automatic t_ovf();
    wr(IDX_MODE, 8'h2A, RESP_OKAY);
    u_src.drive(1'b1, 4);
    u_src.drive(1'b0, 10);
    wr(IDX_IRR, 8'h00, RESP_OKAY);
    u_src.drive(1'b0, 510);
    rdc(IDX_MODE, 8'h6A, "overflow while low");
    rdc(IDX_IRR, 8'h01, "overflow request");
    wr(IDX_MODE, 8'h6A, RESP_OKAY);
    rdc(IDX_MODE, 8'h6A, "flag kept on 1");
    wr(IDX_MODE, 8'h2A, RESP_OKAY);
    rdc(IDX_MODE, 8'h2A, "flag cleared on 0");
    u_src.drive(1'b1, 530);
    rdc(IDX_MODE, 8'hAA, "overflow while high");
    u_src.drive(1'b0, 4);
  endtask

  task automatic t_interval();
    logic [31:0] prev;
    wr(IDX_MODE, 8'h10, RESP_OKAY);
    u_src.drive(1'b1, 10);
    wr(IDX_IRR, 8'h00, RESP_OKAY);
    // Dropping the pin select while the pin is high reads as a falling edge
    wr(IDX_PMR, 8'h00, RESP_OKAY);
    rdc(IDX_IRR, 8'h01, "capture on pin select change");
    u_src.drive(1'b0, 10);
    wr(IDX_MODE, 8'h0A, RESP_OKAY);
    rd(IDX_FALL);
    prev = rd_data;
    u_src.drive(1'b1, 520);
    u_src.drive(1'b0, 10);
    rdc(IDX_FALL, prev[7:0], "no capture when pin masked");
    rdc(IDX_MODE, 8'h4A, "interval overflow");
  endtask

  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    i_clk_sys = 1'b0;
    i_rst = 1'b1;
    i_low_speed = 1'b0;
    i_awvalid = 1'b0;
    i_awaddr = '0;
    i_wvalid = 1'b0;
    i_wdata = '0;
    i_wstrb = 4'hF;
    i_bready = 1'b1;
    i_arvalid = 1'b0;
    i_araddr = '0;
    i_rready = 1'b1;
    errors = 0;
    compares = 0;
    repeat (5) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(posedge i_clk_sys);
    t_reset();
    t_regs();
    t_clk();
    t_irq();
    t_ovf();
    t_interval();
    end_of_test();
  end

  // Whole run needs about 4100 cycles
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule
`default_nettype wire
